// ===== flash_sram_shared_bus_port_tb.sv
// bench: fsbp_host against the memory model
// bus level resolved here from both enables
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module flash_sram_shared_bus_port_tb;
  import fsbp_pkg::*;
  logic mclk_i = 0, rstn_i = 0, req_valid_i = 0, flash_reset_req_i = 0, lock_guard_i = 0;
  fsbp_op_type req_op_i = FSBP_OP_FREAD;
  logic [20:0] req_addr_i = '0, addr_o;
  logic [15:0] req_wdata_i = '0, rsp_rdata_o, dq_i, dq_o, m_dq, flt = '0;
  logic [1:0] req_lane_i = '0;
  logic req_ready_o, rsp_valid_o, dq_oe_o, m_oe, flash_chip_select_o, flash_read_gate_o;
  logic flash_write_strobe_o, flash_reset_n_o, flash_lock_guard_o, sram_select_low_o;
  logic sram_select_high_o, sram_write_strobe_o, sram_read_gate_o, sram_upper_lane_o;
  logic sram_lower_lane_o;
  logic supply_ok = 1;
  int err_total = 0, checks = 0;
  always #5 mclk_i = ~mclk_i;
  // released bus toggles each cycle
  always @(posedge mclk_i) flt <= ~flt;
  assign dq_i = dq_oe_o ? dq_o : m_oe ? m_dq : flt;
  fsbp_host uut (.*);
  fsbp_mem_model u_mem (.*);
  task automatic op(input fsbp_op_type o, input logic [20:0] a, input logic [15:0] w,
    input logic [1:0] l);
    int n;
    n = 0;
    @(negedge mclk_i);
    req_op_i = o;
    req_addr_i = a;
    req_wdata_i = w;
    req_lane_i = l;
    req_valid_i = 1;
    while (req_ready_o !== 1'b1 && n < 40) begin @(negedge mclk_i); n++; end
    @(negedge mclk_i) req_valid_i = 0;
    while (rsp_valid_o !== 1'b1 && n < 80) begin @(negedge mclk_i); n++; end
    `CHK("rsp", 1'b1, rsp_valid_o)
  endtask : op
  task automatic t_boot;
    repeat (FSBP_RST_CYC) @(negedge mclk_i);
    `CHK("boot_rst", 1'b0, flash_reset_n_o)
    @(negedge mclk_i);
    `CHK("boot_rdy", 1'b1, req_ready_o)
    `CHK("boot_pin", 1'b1, flash_reset_n_o)
  endtask : t_boot
  task automatic t_reset;
    while (req_ready_o !== 1'b1) @(negedge mclk_i);
    flash_reset_req_i = 1;
    repeat (3) @(negedge mclk_i);
    `CHK("rst_pin", 1'b0, flash_reset_n_o)
    `CHK("locked", 1'b1, u_mem.locked)
    flash_reset_req_i = 0;
    op(FSBP_OP_FREAD, 21'h00_0f0f, 16'h0000, 2'b00);
    `CHK("rd_rst", 16'h5555, rsp_rdata_o)
  endtask : t_reset
  task automatic t_sram;
    op(FSBP_OP_SWRITE, 21'h00_0003, 16'h1234, 2'b11);
    op(FSBP_OP_SWRITE, 21'h00_0003, 16'habcd, 2'b10);
    op(FSBP_OP_SREAD, 21'h00_0003, 16'h0000, 2'b11);
    `CHK("sram", 16'hab34, rsp_rdata_o)
    op(FSBP_OP_SREAD, 21'h00_0003, 16'h0000, 2'b01);
    `CHK("sram_lo", 8'h34, rsp_rdata_o[7:0])
  endtask : t_sram
  task automatic t_flash;
    supply_ok = 0;
    op(FSBP_OP_FWRITE, 21'h1c_0005, 16'h0060, 2'b00);
    supply_ok = 1;
    repeat (3) @(negedge mclk_i);
    `CHK("cmd_a", 21'h1c_0005, u_mem.cmd_addr)
    `CHK("cmd_d", 16'h0060, u_mem.cmd_data)
    `CHK("prog_lo", 1'b0, u_mem.prog_ok)
    `CHK("guard_lo", 1'b0, u_mem.lock_free)
    op(FSBP_OP_FREAD, 21'h1f_a5a5, 16'h0000, 2'b00);
    `CHK("flash", 16'hffff, rsp_rdata_o)
    @(negedge mclk_i) lock_guard_i = 1;
    repeat (2) @(negedge mclk_i);
    `CHK("guard", 1'b1, flash_lock_guard_o)
    op(FSBP_OP_FWRITE, 21'h00_0002, 16'h00d0, 2'b00);
    supply_ok = 0;
    `CHK("prog_hold", 1'b1, u_mem.prog_ok)
    `CHK("guard_hi", 1'b1, u_mem.lock_free)
    `CHK("unlocked", 1'b0, u_mem.locked)
  endtask : t_flash
  task automatic summarize;
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (16) @(negedge mclk_i);
    rstn_i = 1;
    t_boot;
    t_reset;
    t_sram;
    t_flash;
    t_reset;
    summarize;
  end
  initial
  begin
    #20000;
    err_total++;
    summarize;
  end
endmodule : flash_sram_shared_bus_port_tb
`default_nettype wire

// ===== fsbp_host.sv
// fsbp_host: host controller driving the flash/sram shared bus pins
// assumes one request at a time, memory timings held in the package
`timescale 1ns/10ps
`default_nettype none
module fsbp_host
  import fsbp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // user request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire fsbp_op_type req_op_i,
  input wire logic [FSBP_ADDR_W-1:0] req_addr_i,
  input wire logic [FSBP_DATA_W-1:0] req_wdata_i,
  input wire logic [1:0] req_lane_i,
  input wire logic flash_reset_req_i,
  input wire logic lock_guard_i,
  // user answer
  output logic rsp_valid_o,
  output logic [FSBP_DATA_W-1:0] rsp_rdata_o,
  // memory pins
  output logic [FSBP_ADDR_W-1:0] addr_o,
  input wire logic [FSBP_DATA_W-1:0] dq_i,
  output logic [FSBP_DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic flash_chip_select_o,
  output logic flash_read_gate_o,
  output logic flash_write_strobe_o,
  output logic flash_reset_n_o,
  output logic flash_lock_guard_o,
  output logic sram_select_low_o,
  output logic sram_select_high_o,
  output logic sram_write_strobe_o,
  output logic sram_read_gate_o,
  output logic sram_upper_lane_o,
  output logic sram_lower_lane_o
);
  ////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {FSBP_S_RESET, FSBP_S_IDLE, FSBP_S_SETUP, FSBP_S_STROBE,
    FSBP_S_RECOV} fsbp_state_type;
  fsbp_state_type state_reg, state_next;
  fsbp_op_type op_reg;
  logic [FSBP_ADDR_W-1:0] addr_reg;
  logic [FSBP_DATA_W-1:0] wdata_reg, rdata_reg;
  logic [1:0] lane_reg;
  logic rsp_reg, guard_reg;
  logic t_load, t_done;
  logic [FSBP_CNT_W-1:0] t_count;
  logic booted_reg;
  fsbp_op_type op_next;
  logic [1:0] lane_next;
  logic flash_chip_select_reg, flash_read_gate_reg, flash_write_strobe_reg, flash_reset_n_reg;
  logic sram_select_low_reg, sram_select_high_reg, sram_write_strobe_reg, sram_read_gate_reg;
  logic sram_upper_lane_reg, sram_lower_lane_reg, dq_oe_reg;
  wire logic is_flash = (op_reg == FSBP_OP_FREAD) || (op_reg == FSBP_OP_FWRITE);
  wire logic is_write = (op_reg == FSBP_OP_FWRITE) || (op_reg == FSBP_OP_SWRITE);
  wire logic strobe = (state_reg == FSBP_S_STROBE);
  wire logic accept = (state_reg == FSBP_S_IDLE) && req_valid_i;
  wire logic take = accept && !flash_reset_req_i;
  ////////////////////////////////////////////////////////////////////
  // pin decode; flash and sram selects are exclusive by op
  // decoded from next state so every control pin leaves a flop: no glitch on a strobe
  assign op_next = take ? req_op_i : op_reg;
  assign lane_next = take ? req_lane_i : lane_reg;
  wire logic nx_flash = (op_next == FSBP_OP_FREAD) || (op_next == FSBP_OP_FWRITE);
  wire logic nx_write = (op_next == FSBP_OP_FWRITE) || (op_next == FSBP_OP_SWRITE);
  wire logic nx_bus = (state_next == FSBP_S_SETUP) || (state_next == FSBP_S_STROBE);
  wire logic nx_strobe = (state_next == FSBP_S_STROBE);
  wire logic nx_recov = (state_next == FSBP_S_RECOV);
  wire logic nx_sram = nx_bus && !nx_flash;
  assign addr_o = is_flash ? addr_reg
    : {3'b000, addr_reg[FSBP_SHARED_W-1:0]};
  wire logic flash_reset_n_next = (state_next != FSBP_S_RESET);
  wire logic flash_chip_select_next = ~(nx_bus && nx_flash);
  // the chip select falls on every flash access, so data after a flash reset is valid
  wire logic flash_write_strobe_next = ~(nx_strobe && nx_flash && nx_write);
  wire logic flash_read_gate_next = ~(nx_bus && nx_flash && !nx_write);
  wire logic sram_select_low_next = ~nx_sram;
  wire logic sram_select_high_next = nx_sram;
  wire logic sram_write_strobe_next = ~(nx_strobe && !nx_flash && nx_write);
  wire logic sram_read_gate_next = ~(nx_sram && !nx_write);
  wire logic sram_upper_lane_next = ~(nx_sram && lane_next[1]);
  wire logic sram_lower_lane_next = ~(nx_sram && lane_next[0]);
  // drive held through recovery, two cycles past strobe rise, so latched data is stable
  wire logic dq_oe_next = nx_write && (nx_bus || nx_recov);
  assign flash_reset_n_o = flash_reset_n_reg;
  assign flash_chip_select_o = flash_chip_select_reg;
  assign flash_write_strobe_o = flash_write_strobe_reg;
  assign flash_read_gate_o = flash_read_gate_reg;
  assign flash_lock_guard_o = guard_reg;
  assign sram_select_low_o = sram_select_low_reg;
  assign sram_select_high_o = sram_select_high_reg;
  assign sram_write_strobe_o = sram_write_strobe_reg;
  assign sram_read_gate_o = sram_read_gate_reg;
  assign sram_upper_lane_o = sram_upper_lane_reg;
  assign sram_lower_lane_o = sram_lower_lane_reg;
  assign dq_o = wdata_reg;
  assign dq_oe_o = dq_oe_reg;
  assign req_ready_o = (state_reg == FSBP_S_IDLE);
  assign rsp_valid_o = rsp_reg;
  assign rsp_rdata_o = rdata_reg;
  ////////////////////////////////////////////////////////////////////
  // program supply lockout is sensed by the flash itself; host only sequences
  always_comb
  begin
    state_next = state_reg;
    t_load = 1'b0;
    t_count = 8'h00;
    unique case (state_reg)
      FSBP_S_RESET:
        // first cycle after power-up loads the timer, so no reset request is needed
        if (flash_reset_req_i || !booted_reg)
        begin
          t_load = 1'b1;
          t_count = FSBP_CNT_W'(FSBP_RST_CYC);
        end
        else if (t_done)
        begin
          state_next = FSBP_S_IDLE;
        end
      FSBP_S_IDLE:
        if (flash_reset_req_i)
        begin
          state_next = FSBP_S_RESET;
          t_load = 1'b1;
          t_count = FSBP_CNT_W'(FSBP_RST_CYC);
        end
        else if (req_valid_i)
        begin
          state_next = FSBP_S_SETUP;
          t_load = 1'b1;
          t_count = FSBP_CNT_W'(FSBP_SETUP_CYC);
        end
      FSBP_S_SETUP:
        if (t_done)
        begin
          state_next = FSBP_S_STROBE;
          t_load = 1'b1;
          t_count = FSBP_CNT_W'(is_write ? FSBP_STROBE_CYC : FSBP_ACC_CYC);
        end
      FSBP_S_STROBE:
        if (t_done)
        begin
          state_next = FSBP_S_RECOV;
          t_load = 1'b1;
          t_count = FSBP_CNT_W'(FSBP_RECOV_CYC);
        end
      FSBP_S_RECOV:
        if (t_done)
        begin
          state_next = FSBP_S_IDLE;
        end
    endcase
  end
  fsbp_timer u_timer
  (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .load_i(t_load),
    .count_i(t_count),
    .done_o(t_done)
  );
  ////////////////////////////////////////////////////////////////////
  // reset starts in flash reset so blocks come up locked
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_reg <= FSBP_S_RESET;
      guard_reg <= 1'b0;
      booted_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      guard_reg <= lock_guard_i;
      booted_reg <= 1'b1;
    end
  end
  // pins come up idle with the flash held in reset
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      flash_chip_select_reg <= 1'b1;
      flash_read_gate_reg <= 1'b1;
      flash_write_strobe_reg <= 1'b1;
      flash_reset_n_reg <= 1'b0;
      sram_select_low_reg <= 1'b1;
      sram_select_high_reg <= 1'b0;
      sram_write_strobe_reg <= 1'b1;
      sram_read_gate_reg <= 1'b1;
      sram_upper_lane_reg <= 1'b1;
      sram_lower_lane_reg <= 1'b1;
      dq_oe_reg <= 1'b0;
    end
    else
    begin
      flash_chip_select_reg <= flash_chip_select_next;
      flash_read_gate_reg <= flash_read_gate_next;
      flash_write_strobe_reg <= flash_write_strobe_next;
      flash_reset_n_reg <= flash_reset_n_next;
      sram_select_low_reg <= sram_select_low_next;
      sram_select_high_reg <= sram_select_high_next;
      sram_write_strobe_reg <= sram_write_strobe_next;
      sram_read_gate_reg <= sram_read_gate_next;
      sram_upper_lane_reg <= sram_upper_lane_next;
      sram_lower_lane_reg <= sram_lower_lane_next;
      dq_oe_reg <= dq_oe_next;
    end
  end
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      op_reg <= FSBP_OP_FREAD;
      addr_reg <= 21'h00_0000;
      wdata_reg <= 16'h0000;
      lane_reg <= 2'b00;
    end
    else if (take)
    begin
      op_reg <= req_op_i;
      addr_reg <= req_addr_i;
      wdata_reg <= req_wdata_i;
      lane_reg <= req_lane_i;
    end
  end
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rsp_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      rsp_reg <= strobe && t_done;
      if (strobe && t_done && !is_write)
      begin
        rdata_reg <= dq_i;
      end
    end
  end
endmodule : fsbp_host
`default_nettype wire

// ===== fsbp_mem_model.sv
// model of the flash and sram on the shared bus
// ports carry the host pin names; dq_i is the resolved bus
`timescale 1ns/10ps
`default_nettype none
module fsbp_mem_model (
  // host pins and supply level
  input wire logic [20:0] addr_o,
  input wire logic [15:0] dq_i,
  input wire logic flash_chip_select_o, flash_read_gate_o, flash_write_strobe_o,
  input wire logic flash_reset_n_o, sram_select_low_o, sram_select_high_o,
  input wire logic sram_write_strobe_o, sram_read_gate_o, sram_upper_lane_o, sram_lower_lane_o,
  input wire logic flash_lock_guard_o, supply_ok,
  // model drive
  output logic [15:0] m_dq,
  output logic m_oe
);
  logic [15:0] sram [16];
  logic [20:0] cmd_addr;
  logic [15:0] cmd_data, wd, sw;
  logic armed = 1'b0;
  logic locked = 1'b1, lock_free = 1'b0, prog_ok = 1'b0, fresh = 1'b0;
  wire logic [15:0] fd = addr_o[15:0] ^ 16'h5a5a;
  // reset locks every block and leaves output data stale until reselected or the address changes
  always @(negedge flash_reset_n_o) {locked, fresh} = 2'b10;
  always @(negedge flash_chip_select_o, addr_o) fresh = flash_reset_n_o;
  wire f_on = !flash_chip_select_o && flash_reset_n_o;
  wire s_on = !sram_select_low_o && sram_select_high_o;
  wire f_rd = f_on && !flash_read_gate_o;
  assign sw = sram[addr_o[3:0]];
  assign m_oe = f_rd || (s_on && !sram_read_gate_o);
  // disabled lane shows the inverted byte, so stale data never matches
  assign m_dq = f_rd ? (fresh ? fd : ~fd) : {sram_upper_lane_o ? ~sw[15:8] : sw[15:8],
    sram_lower_lane_o ? ~sw[7:0] : sw[7:0]};
  always @(negedge flash_write_strobe_o) armed = f_on;
  always @(posedge flash_write_strobe_o, posedge flash_chip_select_o)
    if (armed)
    begin
      {cmd_addr, cmd_data, armed} = {addr_o, dq_i, 1'b0};
      // supply level taken only as the operation starts
      prog_ok = supply_ok;
      lock_free = flash_lock_guard_o;
      if (lock_free) locked = 1'b0;
    end
  always @(s_on, sram_write_strobe_o, addr_o, dq_i)
    if (s_on && !sram_write_strobe_o) begin
      wd = sw;
      if (!sram_upper_lane_o) wd[15:8] = dq_i[15:8];
      if (!sram_lower_lane_o) wd[7:0] = dq_i[7:0];
      sram[addr_o[3:0]] = wd;
    end
endmodule : fsbp_mem_model
`default_nettype wire

// ===== fsbp_monitor.sv
// checker: pin rules the host keeps
// sees only fsbp_host ports, bound below
`timescale 1ns/10ps
`default_nettype none
module fsbp_monitor (
  // clock, reset, user
  input wire logic mclk_i, rstn_i, lock_guard_i,
  // memory pins
  input wire logic [20:0] addr_o,
  input wire logic dq_oe_o, flash_chip_select_o, flash_read_gate_o, flash_write_strobe_o,
  input wire logic flash_reset_n_o, flash_lock_guard_o, sram_select_low_o,
  input wire logic sram_select_high_o, sram_write_strobe_o, sram_read_gate_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire s_on = !sram_select_low_o && sram_select_high_o;
  sequence s_wr_phase;
    !flash_write_strobe_o [*5] ##1 flash_write_strobe_o;
  endsequence
  a_no_dual_sel: assert property (!(s_on && !flash_chip_select_o))
    else $error("dual select");
  a_sram_addr_top: assert property (s_on |-> addr_o[20:18] == 3'h0)
    else $error("sram top address");
  a_sram_wr_sel: assert property (!sram_write_strobe_o |-> s_on && dq_oe_o)
    else $error("sram write select");
  a_flash_rd_free: assert property (!flash_read_gate_o |-> !flash_chip_select_o && !dq_oe_o)
    else $error("flash read contention");
  a_sram_rd_free: assert property (!sram_read_gate_o |-> s_on && !dq_oe_o)
    else $error("sram read contention");
  a_flash_wr_len: assert property ($fell(flash_write_strobe_o) |-> s_wr_phase)
    else $error("flash strobe length");
  a_reset_pin_idle: assert property (!flash_reset_n_o |-> flash_chip_select_o)
    else $error("select in reset");
  a_guard_follow: assert property (1 |=> flash_lock_guard_o == $past(lock_guard_i))
    else $error("guard pin");
endmodule : fsbp_monitor
bind fsbp_host fsbp_monitor u_mon (.mclk_i(mclk_i), .rstn_i(rstn_i), .lock_guard_i(lock_guard_i),
  .addr_o(addr_o), .dq_oe_o(dq_oe_o), .flash_chip_select_o(flash_chip_select_o),
  .flash_read_gate_o(flash_read_gate_o), .flash_write_strobe_o(flash_write_strobe_o),
  .flash_reset_n_o(flash_reset_n_o), .flash_lock_guard_o(flash_lock_guard_o),
  .sram_select_low_o(sram_select_low_o), .sram_select_high_o(sram_select_high_o),
  .sram_write_strobe_o(sram_write_strobe_o), .sram_read_gate_o(sram_read_gate_o));
`default_nettype wire

// ===== fsbp_pkg.sv
// fsbp_pkg: constants for the host-side controller of a shared flash/sram bus
// assumes a 100 MHz host clock and a pin-level asynchronous memory outside
// What this block does
// - low address shared, upper address flash only
// - after reset, reselect before trusting data
// - sram write by selects, write strobe low
// - never select flash and sram together
// - keep other memory floating during reads
package fsbp_pkg;
  localparam int FSBP_ADDR_W = 21;
  localparam int FSBP_SHARED_W = 18;
  localparam int FSBP_DATA_W = 16;
  localparam int FSBP_CLK_PS = 10000;
  // access and strobe times, ns, plain defaults
  localparam int FSBP_T_ACC_NS = 70;
  localparam int FSBP_T_SETUP_NS = 20;
  localparam int FSBP_T_STROBE_NS = 50;
  localparam int FSBP_T_RECOV_NS = 20;
  localparam int FSBP_T_RST_NS = 100;
  // least times round up
  localparam int FSBP_ACC_CYC = (FSBP_T_ACC_NS * 1000 + FSBP_CLK_PS - 1) / FSBP_CLK_PS;
  localparam int FSBP_SETUP_CYC = (FSBP_T_SETUP_NS * 1000 + FSBP_CLK_PS - 1) / FSBP_CLK_PS;
  localparam int FSBP_STROBE_CYC = (FSBP_T_STROBE_NS * 1000 + FSBP_CLK_PS - 1) / FSBP_CLK_PS;
  localparam int FSBP_RECOV_CYC = (FSBP_T_RECOV_NS * 1000 + FSBP_CLK_PS - 1) / FSBP_CLK_PS;
  localparam int FSBP_RST_CYC = (FSBP_T_RST_NS * 1000 + FSBP_CLK_PS - 1) / FSBP_CLK_PS;
  localparam int FSBP_CNT_W = 8;
  typedef enum logic [1:0] {FSBP_OP_FREAD, FSBP_OP_FWRITE, FSBP_OP_SREAD, FSBP_OP_SWRITE}
    fsbp_op_type;
endpackage : fsbp_pkg

// ===== fsbp_timer.sv
// fsbp_timer: loadable down counter giving a one-cycle done pulse
// assumes load and count come from the same clock domain
`timescale 1ns/10ps
`default_nettype none
module fsbp_timer
  import fsbp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rstn_i,
  // control
  input wire logic load_i,
  input wire logic [FSBP_CNT_W-1:0] count_i,
  output logic done_o
);
  logic [FSBP_CNT_W-1:0] cnt_reg;
  logic run_reg;
  assign done_o = run_reg && (cnt_reg == 8'h01);
  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg <= 8'h00;
      run_reg <= 1'b0;
    end
    else if (load_i)
    begin
      cnt_reg <= count_i;
      run_reg <= 1'b1;
    end
    else if (run_reg)
    begin
      cnt_reg <= cnt_reg - 8'h01;
      run_reg <= (cnt_reg != 8'h01);
    end
  end
endmodule : fsbp_timer
`default_nettype wire
